/* File: logic/seq_pkg.sv */
// constants for the control write sequencer: register map, field layout, timing
// assumes a 100 MHz core system clock and 8-bit control register addresses
package seq_pkg;
	// register offsets on the control interface
	localparam logic [7:0] PROG_POINTER_ADDR = 8'h6C;
	localparam logic [7:0] TARGET_CONFIG_ADDR = 8'h6D;
	localparam logic [7:0] PAYLOAD_ADDR = 8'h6E;
	localparam logic [7:0] LAUNCH_CTRL_ADDR = 8'h6F;
	localparam logic [7:0] STATUS_ADDR = 8'h70;
	localparam logic [7:0] SOFT_RESET_ADDR = 8'h00;

	// field positions
	localparam int SPAN_LSB = 12;
	localparam int POS_LSB = 8;
	localparam int LAST_BIT = 14;
	localparam int WAIT_LSB = 8;
	localparam int LAUNCH_BIT = 8;
	localparam int CANCEL_BIT = 9;
	localparam int CUR_INDEX_LSB = 4;
	localparam int RUNNING_BIT = 0;

	// writable field masks and reset values
	localparam logic [15:0] TARGET_CONFIG_MASK = 16'h7FFF;
	localparam logic [15:0] PAYLOAD_MASK = 16'h4FFF;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [4:0] POINTER_RESET = 5'h00;
	localparam logic [5:0] INDEX_RESET = 6'h00;

	// memory layout
	localparam int RAM_DEPTH = 32;
	localparam logic [5:0] ROM_FIRST = 6'd32;
	localparam logic [5:0] ROM_LAST = 6'd48;

	// step timing: one unit is 62.5 us
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_UNIT_NS = 62500;
	localparam int STEP_UNIT_CYCLES = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] WAIT_BASE_UNITS = 16'h0008;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_FETCH,
		SEQ_EXEC,
		SEQ_WAIT
	} seq_state_t;
endpackage : seq_pkg

/* File: logic/step_memory.sv */
// step memory: 32 writable entries and 17 fixed entries, synchronous read
// assumes the owner never writes and reads the same entry in one cycle
`timescale 1ns/100ps
module step_memory (
	// clock
	input wire logic ref_clk,
	// program side
	input wire logic targetWrEn,
	input wire logic payloadWrEn,
	input wire logic [4:0] wrIndex,
	input wire logic [15:0] wrData,
	// fetch side
	input wire logic [5:0] rdIndex,
	output logic [15:0] rdTarget,
	output logic [15:0] rdPayload
);
	import seq_pkg::*;

	logic [15:0] targetRam [RAM_DEPTH];
	logic [15:0] payloadRam [RAM_DEPTH];

	// fixed entries: spare write of zero to register FFh, each one ends a sequence;
	// unused and reserved indices read the same so a bad launch stops after one nine-unit step
	function automatic logic [31:0] fixedEntry(input logic [5:0] idx);
		logic [31:0] e;
		e = {16'h4000, 16'h00FF};
		if (idx >= ROM_FIRST && idx <= ROM_LAST) begin
			e = {16'h4000, 16'h00FF};
		end
		return e;
	endfunction : fixedEntry

	logic [31:0] fixedWord;
	always_comb begin
		fixedWord = fixedEntry(rdIndex);
	end

	always_ff @(posedge ref_clk) begin
		if (targetWrEn) begin
			targetRam[wrIndex] <= wrData & TARGET_CONFIG_MASK;
		end
		if (payloadWrEn) begin
			payloadRam[wrIndex] <= wrData & PAYLOAD_MASK;
		end
		if (rdIndex < ROM_FIRST) begin
			rdTarget <= targetRam[rdIndex[4:0]];
			rdPayload <= payloadRam[rdIndex[4:0]];
		end else begin
			rdTarget <= fixedWord[15:0];
			rdPayload <= fixedWord[31:16];
		end
	end
endmodule : step_memory

/* File: logic/write_sequencer.sv */
// control write sequencer: step programming registers, launch/cancel, step execution
// assumes the control interface presents one access per cycle, reads answered next cycle
//
// Function
// - program pointer picks RAM entry 0..31 that receives step register writes
// - entries 32..48 are fixed and cannot be reprogrammed
// - 8-bit target register select names the register the step writes
// - 4-bit LSB position gives bit 0..15 where the field begins
// - 3-bit span code n writes n+1 bits
// - only the covered bits of the target register change
// - only the low span bits of the 8-bit value are written
// - step time is 62.5us times (2^D + 8) from the write, plus two cycles of fetch and execution before the next write
// - last-step flag stops the sequencer after that step
// - target config: span 14:12, position 11:8, select 7:0, reset zero
// - payload: last-step 14, wait 11:8, value 7:0, reset zero
// - launch bit starts at launch pointer and self-clears on completion
// - cancel bit aborts and returns control to the serial interface
// - while running, only sequencer and software reset registers are reachable
// - after the last step, stop and pulse a completion event
`timescale 1ns/100ps
module write_sequencer #(
	parameter int UNIT_CYCLES = seq_pkg::STEP_UNIT_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// control interface register access
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	output logic regRdHit,
	// masked write port into the control register file
	output logic ctlWrEn,
	output logic [7:0] ctlAddr,
	output logic [15:0] ctlMask,
	output logic [15:0] ctlData,
	// status
	output logic runningFlag,
	output logic seqDoneEvent
);
	import seq_pkg::*;

	// field mask of span code n at position p, bits past 15 fall away
	function automatic logic [15:0] fieldMask(input logic [2:0] span, input logic [3:0] pos);
		logic [23:0] m;
		m = {16'h0000, 8'hFF >> (3'd7 - span)};
		m = m << pos;
		return m[15:0];
	endfunction : fieldMask

	function automatic logic [15:0] fieldData(input logic [7:0] val, input logic [2:0] span,
		input logic [3:0] pos);
		logic [23:0] d;
		d = {16'h0000, val & (8'hFF >> (3'd7 - span))};
		d = d << pos;
		return d[15:0];
	endfunction : fieldData

	localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYCLES - 1);

	// host registers
	logic [4:0] progPointer_q, progPointer_d;
	logic [15:0] targetConfig_q, targetConfig_d;
	logic [15:0] payload_q, payload_d;
	logic [5:0] launchPointer_q, launchPointer_d;
	logic [5:0] curIndex_q, curIndex_d;
	// sequencer state
	seq_state_t state_q, state_d;
	logic [31:0] unitCnt_q, unitCnt_d;
	logic [15:0] unitsLeft_q, unitsLeft_d;
	logic lastStep_q, lastStep_d;
	// outputs
	logic [15:0] rdData_q, rdData_d;
	logic rdHit_q, rdHit_d;
	logic ctlWrEn_q, ctlWrEn_d;
	logic [7:0] ctlAddr_q, ctlAddr_d;
	logic [15:0] ctlMask_q, ctlMask_d;
	logic [15:0] ctlData_q, ctlData_d;
	logic done_q, done_d;

	logic targetWrEn, payloadWrEn, launchWr, cancelWr, seqReg, running;
	logic [15:0] memTarget, memPayload;

	assign running = (state_q != SEQ_IDLE);
	assign seqReg = (regAddr >= PROG_POINTER_ADDR) && (regAddr <= STATUS_ADDR);
	assign targetWrEn = regWrEn && (regAddr == TARGET_CONFIG_ADDR);
	assign payloadWrEn = regWrEn && (regAddr == PAYLOAD_ADDR);
	assign launchWr = regWrEn && (regAddr == LAUNCH_CTRL_ADDR) && regWrData[LAUNCH_BIT];
	assign cancelWr = regWrEn && (regAddr == LAUNCH_CTRL_ADDR) && regWrData[CANCEL_BIT];

	step_memory mem (
		.ref_clk(ref_clk),
		.targetWrEn(targetWrEn),
		.payloadWrEn(payloadWrEn),
		.wrIndex(progPointer_q),
		.wrData(regWrData),
		.rdIndex(curIndex_q),
		.rdTarget(memTarget),
		.rdPayload(memPayload)
	);

	// host register file and read path
	always_comb begin
		progPointer_d = progPointer_q;
		targetConfig_d = targetConfig_q;
		payload_d = payload_q;
		launchPointer_d = launchPointer_q;
		if (regWrEn && regAddr == PROG_POINTER_ADDR) begin
			progPointer_d = regWrData[4:0];
		end
		if (targetWrEn) begin
			targetConfig_d = regWrData & TARGET_CONFIG_MASK;
		end
		if (payloadWrEn) begin
			payload_d = regWrData & PAYLOAD_MASK;
		end
		if (regWrEn && regAddr == LAUNCH_CTRL_ADDR && !running) begin
			launchPointer_d = regWrData[5:0];
		end
		rdHit_d = regRdEn && seqReg;
		rdData_d = REG_RESET;
		if (regRdEn) begin
			case (regAddr)
				PROG_POINTER_ADDR: rdData_d = {11'h000, progPointer_q};
				TARGET_CONFIG_ADDR: rdData_d = targetConfig_q;
				PAYLOAD_ADDR: rdData_d = payload_q;
				LAUNCH_CTRL_ADDR: rdData_d = {7'h00, running, 2'b00, launchPointer_q};
				STATUS_ADDR: rdData_d = {6'h00, curIndex_q, 3'b000, running};
				default: rdData_d = REG_RESET;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			progPointer_q <= POINTER_RESET;
			targetConfig_q <= REG_RESET;
			payload_q <= REG_RESET;
			launchPointer_q <= INDEX_RESET;
			rdData_q <= REG_RESET;
			rdHit_q <= 1'b0;
		end else begin
			progPointer_q <= progPointer_d;
			targetConfig_q <= targetConfig_d;
			payload_q <= payload_d;
			launchPointer_q <= launchPointer_d;
			rdData_q <= rdData_d;
			rdHit_q <= rdHit_d;
		end
	end

	// step execution and control register write port
	always_comb begin
		state_d = state_q;
		curIndex_d = curIndex_q;
		unitCnt_d = unitCnt_q;
		unitsLeft_d = unitsLeft_q;
		lastStep_d = lastStep_q;
		done_d = 1'b0;
		ctlWrEn_d = 1'b0;
		ctlAddr_d = ctlAddr_q;
		ctlMask_d = ctlMask_q;
		ctlData_d = ctlData_q;
		// host writes pass through only while idle, software reset always
		if (regWrEn && !seqReg && (!running || regAddr == SOFT_RESET_ADDR)) begin
			ctlWrEn_d = 1'b1;
			ctlAddr_d = regAddr;
			ctlMask_d = 16'hFFFF;
			ctlData_d = regWrData;
		end
		case (state_q)
			SEQ_IDLE: begin
				if (launchWr && !cancelWr) begin
					curIndex_d = regWrData[5:0];
					state_d = SEQ_FETCH;
				end
			end
			SEQ_FETCH: begin
				state_d = SEQ_EXEC;
			end
			SEQ_EXEC: begin
				// step timing begins with the write itself
				if (!ctlWrEn_d) begin
					ctlWrEn_d = 1'b1;
					ctlAddr_d = memTarget[7:0];
					ctlMask_d = fieldMask(memTarget[14:12], memTarget[11:8]);
					ctlData_d = fieldData(memPayload[7:0], memTarget[14:12], memTarget[11:8]);
				end
				lastStep_d = memPayload[LAST_BIT];
				unitsLeft_d = (16'h0001 << memPayload[11:8]) + WAIT_BASE_UNITS;
				unitCnt_d = 32'h0000_0000;
				state_d = SEQ_WAIT;
			end
			SEQ_WAIT: begin
				// fetch and execution of the next entry add two cycles after the current step time
				if (unitCnt_q == UNIT_LAST) begin
					unitCnt_d = 32'h0000_0000;
					unitsLeft_d = unitsLeft_q - 16'h0001;
					if (unitsLeft_q == 16'h0001) begin
						if (lastStep_q) begin
							state_d = SEQ_IDLE;
							done_d = 1'b1;
						end else begin
							curIndex_d = curIndex_q + 6'd1;
							state_d = SEQ_FETCH;
						end
					end
				end else begin
					unitCnt_d = unitCnt_q + 32'h0000_0001;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
		if (cancelWr) begin
			state_d = SEQ_IDLE;
			done_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= SEQ_IDLE;
			curIndex_q <= INDEX_RESET;
			unitCnt_q <= 32'h0000_0000;
			unitsLeft_q <= 16'h0000;
			lastStep_q <= 1'b0;
			done_q <= 1'b0;
			ctlWrEn_q <= 1'b0;
			ctlAddr_q <= 8'h00;
			ctlMask_q <= 16'h0000;
			ctlData_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			curIndex_q <= curIndex_d;
			unitCnt_q <= unitCnt_d;
			unitsLeft_q <= unitsLeft_d;
			lastStep_q <= lastStep_d;
			done_q <= done_d;
			ctlWrEn_q <= ctlWrEn_d;
			ctlAddr_q <= ctlAddr_d;
			ctlMask_q <= ctlMask_d;
			ctlData_q <= ctlData_d;
		end
	end

	assign regRdData = rdData_q;
	assign regRdHit = rdHit_q;
	assign ctlWrEn = ctlWrEn_q;
	assign ctlAddr = ctlAddr_q;
	assign ctlMask = ctlMask_q;
	assign ctlData = ctlData_q;
	assign runningFlag = running;
	assign seqDoneEvent = done_q;
endmodule : write_sequencer

/* File: dv/write_sequencer_properties.sv */
// port checker for write_sequencer
// assumes one clock domain, bound from the testbench
`timescale 1ns/100ps
module write_sequencer_properties #(
	parameter int UNIT_CYCLES = 2
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// host side
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic regRdHit,
	// control writes and status
	input wire logic ctlWrEn,
	input wire logic [7:0] ctlAddr,
	input wire logic [15:0] ctlMask,
	input wire logic [15:0] ctlData,
	input wire logic runningFlag,
	input wire logic seqDoneEvent
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic seqReg;
	logic launchWr;
	assign seqReg = regAddr inside {[8'h6C:8'h70]};
	assign launchWr = regWrEn && regAddr == 8'h6F;
	a_read_hit: assert property (regRdEn && seqReg |=> regRdHit) else $error("read hit missing");
	a_read_miss: assert property (regRdEn && !seqReg |=> !regRdHit && regRdData == 16'h0000)
		else $error("foreign read answered");
	a_pass_thru: assert property (!runningFlag && regWrEn && !seqReg |=> ctlWrEn && ctlMask == 16'hFFFF
		&& ctlAddr == $past(regAddr) && ctlData == $past(regWrData)) else $error("host write lost");
	a_busy_block: assert property (runningFlag && regWrEn && !seqReg && regAddr != 8'h00
		|=> !(ctlWrEn && ctlMask == 16'hFFFF)) else $error("host write while running");
	a_reset_pass: assert property (runningFlag && regWrEn && regAddr == 8'h00 |=> ctlWrEn && ctlAddr == 8'h00
		&& ctlMask == 16'hFFFF) else $error("reset write blocked");
	a_data_masked: assert property (ctlWrEn |-> (ctlData & ~ctlMask) == 16'h0000) else $error("data outside mask");
	a_span_shape: assert property (ctlWrEn && ctlMask != 16'hFFFF |-> $countones(ctlMask) inside {[1:8]}
		&& (((ctlMask | (ctlMask - 16'h0001)) + 16'h0001) & ctlMask) == 16'h0000) else $error("bad step mask");
	a_launch_start: assert property (!runningFlag && launchWr && regWrData[8] && !regWrData[9]
		|=> runningFlag [*2] ##1 ctlWrEn) else $error("launch not started");
	a_cancel_stop: assert property (launchWr && regWrData[9] |=> !runningFlag && !seqDoneEvent)
		else $error("cancel ignored");
	a_done_fall: assert property (seqDoneEvent |-> !runningFlag && $past(runningFlag)) else $error("stray done");
	c_launch: cover property (launchWr && regWrData[8] && !runningFlag);
	c_done: cover property (seqDoneEvent);
	c_cancel: cover property (launchWr && regWrData[9] && runningFlag);
	c_soft_reset: cover property (runningFlag && regWrEn && regAddr == 8'h00);
endmodule : write_sequencer_properties

/* File: dv/ctl_reg_model.sv */
// control register file model receiving masked writes
// assumes ctlWrEn pulses one cycle per write
`timescale 1ns/100ps
module ctl_reg_model (
	// clock
	input wire logic ref_clk,
	// masked write
	input wire logic ctlWrEn,
	input wire logic [7:0] ctlAddr,
	input wire logic [15:0] ctlMask,
	input wire logic [15:0] ctlData,
	// bench peek
	input wire logic [7:0] peekAddr,
	output logic [15:0] peekData
);
	logic [15:0] regs [256];
	initial foreach (regs[k]) regs[k] = 16'h0000;
	always @(posedge ref_clk) if (ctlWrEn) regs[ctlAddr] <= (regs[ctlAddr] & ~ctlMask) | (ctlData & ctlMask);
	assign peekData = regs[peekAddr];
endmodule : ctl_reg_model

/* File: dv/testbench.sv */
// self-checking bench for write_sequencer
// assumes 100 MHz ref_clk and a shortened step unit
`timescale 1ns/100ps
module testbench;
	import seq_pkg::*;
	localparam int UNIT = 2;
	logic ref_clk, reset, regWrEn, regRdEn, regRdHit, ctlWrEn, runningFlag, seqDoneEvent, rdSeen;
	logic [7:0] regAddr, ctlAddr, peekAddr;
	logic [15:0] regWrData, regRdData, ctlMask, ctlData, peekData, w;
	logic [16:0] rdQ[$];
	logic [39:0] ctlQ[$];
	logic [39:0] x;
	time tq[$];
	time doneT;
	int fail_count, total_checks, doneCount, i;
	logic [2:0] sp;
	logic [3:0] ps;
	logic [7:0] vl;
	write_sequencer #(.UNIT_CYCLES(UNIT)) i_dut (.ref_clk(ref_clk), .reset(reset), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdHit(regRdHit),
		.ctlWrEn(ctlWrEn), .ctlAddr(ctlAddr), .ctlMask(ctlMask), .ctlData(ctlData), .runningFlag(runningFlag),
		.seqDoneEvent(seqDoneEvent));
	ctl_reg_model i_model (.ref_clk(ref_clk), .ctlWrEn(ctlWrEn), .ctlAddr(ctlAddr), .ctlMask(ctlMask),
		.ctlData(ctlData), .peekAddr(peekAddr), .peekData(peekData));
	task automatic cmp(input logic [39:0] g, input logic [39:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic chk_rd(input logic [16:0] g, input logic [16:0] e);
		cmp({23'h0, g}, {23'h0, e});
	endtask : chk_rd
	task automatic chk_ctl(input logic [39:0] g, input logic [39:0] e);
		cmp(g, e);
	endtask : chk_ctl
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge ref_clk);
		regWrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [16:0] e);
		rdQ.push_back(e);
		@(negedge ref_clk);
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge ref_clk);
		regRdEn = 1'b0;
	endtask : rd
	task automatic wait_done;
		for (int n = 0; n < 300 && !seqDoneEvent; n++) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask : wait_done
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// span n writes n+1 bits from pos; upper value bits dropped
	function automatic logic [39:0] stepx(input logic [7:0] a, input logic [2:0] s, input logic [3:0] p,
		input logic [7:0] d);
		logic [31:0] m;
		m = ((32'h1 << (s + 1)) - 1) << p;
		return {a, m[15:0], m[15:0] & ({8'h00, d} << p)};
	endfunction : stepx
	always @(posedge ref_clk) rdSeen <= regRdEn;
	always @(negedge ref_clk) begin
		if (rdSeen) chk_rd({regRdHit, regRdData}, rdQ.pop_front());
		if (ctlWrEn) begin
			if (ctlMask != 16'hFFFF) tq.push_back($time);
			chk_ctl({ctlAddr, ctlMask, ctlData}, ctlQ.pop_front());
		end
		if (seqDoneEvent) begin
			doneT = $time;
			doneCount++;
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		fail_count++;
		end_sim();
	end
	initial begin
		reset = 1'b1;
		{regWrEn, regRdEn, regAddr, regWrData, peekAddr} = '0;
		void'($urandom(77759));
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		for (i = 0; i < 5; i++) rd(8'(8'h6C + i), 17'h1_0000);
		rd(8'h21, 17'h0_0000);
		w = 16'($urandom);
		ctlQ.push_back({8'h20, 16'hFFFF, w});
		wr(8'h20, w);
		for (i = 0; i < 3; i++) begin
			sp = 3'($urandom);
			ps = 4'($urandom);
			vl = 8'($urandom);
			wr(PROG_POINTER_ADDR, 16'(5 + i));
			wr(TARGET_CONFIG_ADDR, {1'b1, sp, ps, 8'h20});
			wr(PAYLOAD_ADDR, {1'b1, (i == 2), 2'b11, 3'b000, (i == 1), vl});
			rd(PROG_POINTER_ADDR, 17'(17'h1_0005 + i));
			rd(TARGET_CONFIG_ADDR, {2'b10, sp, ps, 8'h20});
			rd(PAYLOAD_ADDR, {2'b10, (i == 2), 5'b00000, (i == 1), vl});
			x = stepx(8'h20, sp, ps, vl);
			ctlQ.push_back(x);
			w = (w & ~x[31:16]) | x[15:0];
		end
		wr(LAUNCH_CTRL_ADDR, 16'h0105);
		wr(8'h21, 16'hFFFF);
		rd(LAUNCH_CTRL_ADDR, 17'h1_0105);
		wait_done();
		chk_ctl(40'(tq[1] - tq[0]), 40'(10 * (UNIT * 9 + 2)));
		chk_ctl(40'(tq[2] - tq[1]), 40'(10 * (UNIT * 10 + 2)));
		chk_ctl(40'(doneT - tq[2]), 40'(10 * UNIT * 9));
		rd(STATUS_ADDR, 17'h1_0070);
		rd(LAUNCH_CTRL_ADDR, 17'h1_0005);
		peekAddr = 8'h20;
		#1 chk_rd({1'b1, peekData}, {1'b1, w});
		wr(PROG_POINTER_ADDR, 16'h0008);
		wr(TARGET_CONFIG_ADDR, 16'h0022);
		wr(PAYLOAD_ADDR, 16'h0301);
		ctlQ.push_back(40'h22_0001_0001);
		wr(LAUNCH_CTRL_ADDR, 16'h0108);
		repeat (5) @(negedge ref_clk);
		// software reset register stays reachable while running
		ctlQ.push_back({8'h00, 16'hFFFF, 16'h5A5A});
		wr(SOFT_RESET_ADDR, 16'h5A5A);
		// relaunch while running must be ignored, pointer kept
		wr(LAUNCH_CTRL_ADDR, 16'h0105);
		wr(LAUNCH_CTRL_ADDR, 16'h0200);
		rd(STATUS_ADDR, 17'h1_0080);
		rd(LAUNCH_CTRL_ADDR, 17'h1_0008);
		chk_ctl(40'(doneCount), 40'h1);
		wr(PROG_POINTER_ADDR, 16'h0020);
		rd(PROG_POINTER_ADDR, 17'h1_0000);
		ctlQ.push_back(40'hFF_0001_0000);
		wr(LAUNCH_CTRL_ADDR, 16'h0120);
		wait_done();
		chk_ctl(40'(doneCount), 40'h2);
		// twelve-bit field split over two steps
		w = 16'($urandom);
		wr(PROG_POINTER_ADDR, 16'h0000);
		wr(TARGET_CONFIG_ADDR, 16'h7030);
		wr(PAYLOAD_ADDR, {8'h00, w[7:0]});
		wr(PROG_POINTER_ADDR, 16'h0001);
		wr(TARGET_CONFIG_ADDR, 16'h3830);
		wr(PAYLOAD_ADDR, {8'h40, 4'h0, w[11:8]});
		ctlQ.push_back(stepx(8'h30, 3'd7, 4'd0, w[7:0]));
		ctlQ.push_back(stepx(8'h30, 3'd3, 4'd8, {4'h0, w[11:8]}));
		wr(LAUNCH_CTRL_ADDR, 16'h0100);
		wait_done();
		peekAddr = 8'h30;
		#1 chk_rd({1'b1, peekData}, {5'h10, w[11:0]});
		chk_ctl(40'(doneCount), 40'h3);
		repeat (3) @(negedge ref_clk);
		chk_ctl(40'(ctlQ.size()), 40'h0);
		end_sim();
	end
endmodule : testbench
bind write_sequencer write_sequencer_properties #(.UNIT_CYCLES(UNIT_CYCLES)) i_props (.ref_clk(ref_clk),
	.reset(reset), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
	.regRdData(regRdData), .regRdHit(regRdHit), .ctlWrEn(ctlWrEn), .ctlAddr(ctlAddr), .ctlMask(ctlMask),
	.ctlData(ctlData), .runningFlag(runningFlag), .seqDoneEvent(seqDoneEvent));
